// *** hw/pxb_pkg.sv ***
// Package with the constants and types of the port crossbar and pin configuration block.
package pxb_pkg;

  localparam int PORT_COUNT    = 3;
  localparam int PORT_WIDTH    = 8;
  localparam int PIN_COUNT     = PORT_COUNT * PORT_WIDTH;
  localparam int PIN_IDX_WIDTH = $clog2(PIN_COUNT + 1);

  // Fixed pins of the serial port: port 0 bit 4 and port 0 bit 5.
  localparam int UART_TX_PIN = 4;
  localparam int UART_RX_PIN = 5;

  // Priority slots of the crossbar scan, highest priority first.
  localparam int SIG_SCK    = 0;
  localparam int SIG_MISO   = 1;
  localparam int SIG_MOSI   = 2;
  localparam int SIG_SS     = 3;
  localparam int SIG_SDA    = 4;
  localparam int SIG_SCL    = 5;
  localparam int SIG_CMP    = 6;
  localparam int SIG_CMPA   = 7;
  localparam int SIG_SYSCLK = 8;
  localparam int SIG_COUNTER_ARRAY_CHANNEL_IO   = 9;
  localparam int SIG_CEX1   = 10;
  localparam int SIG_CEX2   = 11;
  localparam int SIG_ECI    = 12;
  localparam int SIG_T0     = 13;
  localparam int SIG_T1     = 14;
  localparam int SIG_COUNT  = 15;
  localparam int SIG_IDX_WIDTH = $clog2(SIG_COUNT + 1);

  // Counter array route field codes.
  localparam logic [1:0] CEX_NONE = 2'h0;
  localparam logic [1:0] CEX_ONE  = 2'h1;
  localparam logic [1:0] CEX_TWO  = 2'h2;
  localparam logic [1:0] CEX_ALL  = 2'h3;

  // Reset value of the input mode bits seen by the pins, and the slot code of a pin that no signal owns.
  localparam logic [PIN_COUNT-1:0] INPUT_MODE_RESET = {PIN_COUNT{1'b1}};
  localparam logic [SIG_IDX_WIDTH-1:0] SIG_NONE = SIG_IDX_WIDTH'(SIG_COUNT);

  // Pin owner: general port I/O, the fixed serial port, or a crossbar slot.
  typedef enum logic [2:0]
  {
    OWN_GPIO = 3'h1,
    OWN_UART = 3'h2,
    OWN_XBAR = 3'h4
  } pxb_owner_type;

endpackage

// *** hw/pxb_pin_cell.sv ***
// One pin's output driver, pullup and input receiver control.
`timescale 1ns/1ns
module pxb_pin_cell
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic digital_mode,
  input  wire logic push_pull,
  input  wire logic force_open_drain,
  input  wire logic pullup_disable,
  input  wire logic drive_en,
  input  wire logic drive_val,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n,
  output logic      pullup_on,
  output logic      pin_sense
);

  logic sync1_q;
  logic sync2_q;
  logic low_drive;
  logic high_drive;
  logic is_open_drain;

  assign is_open_drain = force_open_drain | ~push_pull;
  assign low_drive  = digital_mode & drive_en & ~drive_val;
  assign high_drive = digital_mode & drive_en & drive_val & ~is_open_drain;

  // ---------------------------------------------------------------
  // Registered pad controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end
    else
    begin
      pin_out  <= drive_val;
      pin_oe_n <= ~(low_drive | high_drive);
    end
  end

  // A pullup fighting a driven low only burns current, so it is dropped then.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pullup_on <= 1'b1;
    else
      pullup_on <= digital_mode & is_open_drain & ~pullup_disable & ~low_drive;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q   <= 1'b0;
      sync2_q   <= 1'b0;
      pin_sense <= 1'b0;
    end
    else
    begin
      sync1_q   <= pin_in;
      sync2_q   <= sync1_q;
      pin_sense <= digital_mode & sync2_q;
    end
  end

endmodule

// *** hw/pxb_crossbar.sv ***
// Top of the port crossbar: priority pin assignment and per-pin configuration.
`timescale 1ns/1ns
module pxb_crossbar
  import pxb_pkg::*;
#(
  parameter int NUM_PORTS = pxb_pkg::PORT_COUNT
)
(
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic [pxb_pkg::PIN_COUNT-1:0] pin_skip_mask,
  input  wire logic [pxb_pkg::PIN_COUNT-1:0] input_mode_select,
  input  wire logic [pxb_pkg::PIN_COUNT-1:0] output_drive_select,
  input  wire logic                          matrix_enable,
  input  wire logic                          pullup_disable,
  input  wire logic                          uart_route_en,
  input  wire logic                          spi_route_en,
  input  wire logic                          spi_four_wire,
  input  wire logic                          smbus_route_en,
  input  wire logic                          cmp_route_en,
  input  wire logic                          cmp_async_route_en,
  input  wire logic                          sysclk_route_en,
  input  wire logic [1:0]                    counter_array_route_field,
  input  wire logic                          eci_route_en,
  input  wire logic                          t0_route_en,
  input  wire logic                          t1_route_en,
  input  wire logic [pxb_pkg::PIN_COUNT-1:0] gpio_out_val,
  input  wire logic                          uart_transmit,
  input  wire logic [pxb_pkg::SIG_COUNT-1:0] periph_out_val,
  input  wire logic [pxb_pkg::SIG_COUNT-1:0] periph_out_en,
  input  wire logic [pxb_pkg::PIN_COUNT-1:0] pin_in,
  output logic      [pxb_pkg::PIN_COUNT-1:0] pin_out,
  output logic      [pxb_pkg::PIN_COUNT-1:0] pin_oe_n,
  output logic      [pxb_pkg::PIN_COUNT-1:0] pin_pullup_en,
  output logic      [pxb_pkg::PIN_COUNT-1:0] port_in_val,
  output logic                               uart_receive,
  output logic      [pxb_pkg::SIG_COUNT-1:0] periph_in_val,
  output logic      [pxb_pkg::SIG_COUNT-1:0] sig_placed
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The pin tables are sized from the package, so only that port count is served.
  if (NUM_PORTS != PORT_COUNT)
  begin : g_check
    $error("pxb_crossbar serves exactly the fixed port count");
  end

  if (UART_TX_PIN >= PORT_WIDTH || UART_RX_PIN >= PORT_WIDTH || UART_TX_PIN == UART_RX_PIN)
  begin : g_check_uart
    $error("pxb_crossbar needs two distinct serial pins inside port 0");
  end

  // One slot code above the last signal marks a pin that no signal owns.
  if (SIG_COUNT >= (1 << SIG_IDX_WIDTH))
  begin : g_check_slot
    $error("pxb_crossbar needs a spare slot code for unowned pins");
  end

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_sync1_q;
  logic rst_n;

  // Reset is taken at once but released on a clock edge, so that every flop
  // leaves reset in the same cycle and no pad sees a half-released state.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_sync1_q <= 1'b0;
      rst_n       <= 1'b0;
    end
    else
    begin
      rst_sync1_q <= 1'b1;
      rst_n       <= rst_sync1_q;
    end
  end

  // ---------------------------------------------------------------
  // Signal requests
  // ---------------------------------------------------------------
  logic [SIG_COUNT-1:0] sig_req;
  logic [2:0]           cex_req;

  // Higher codes only add channels; channel 1 is never routed without channel 0.
  // Counter channel decode
  always_comb
  begin
    case (counter_array_route_field)
      CEX_NONE: cex_req = 3'h0;
      CEX_ONE:  cex_req = 3'h1;
      CEX_TWO:  cex_req = 3'h3;
      CEX_ALL:  cex_req = 3'h7;
      default:  cex_req = 3'h0;
    endcase
  end

  // Requests are levels; a change of any route enable re-runs the scan at once.
  always_comb
  begin
    sig_req             = '0;
    sig_req[SIG_SCK]    = spi_route_en;
    sig_req[SIG_MISO]   = spi_route_en;
    sig_req[SIG_MOSI]   = spi_route_en;
    sig_req[SIG_SS]     = spi_route_en & spi_four_wire;
    sig_req[SIG_SDA]    = smbus_route_en;
    sig_req[SIG_SCL]    = smbus_route_en;
    sig_req[SIG_CMP]    = cmp_route_en;
    sig_req[SIG_CMPA]   = cmp_async_route_en;
    sig_req[SIG_SYSCLK] = sysclk_route_en;
    sig_req[SIG_COUNTER_ARRAY_CHANNEL_IO]   = cex_req[0];
    sig_req[SIG_CEX1]   = cex_req[1];
    sig_req[SIG_CEX2]   = cex_req[2];
    sig_req[SIG_ECI]    = eci_route_en;
    sig_req[SIG_T0]     = t0_route_en;
    sig_req[SIG_T1]     = t1_route_en;
  end

  // ---------------------------------------------------------------
  // Priority scan
  // ---------------------------------------------------------------
  // Special pins unplaced
  // Special function pins have no slot here; uart_pins marks the serial pins taken before the scan starts.
  logic [PIN_COUNT-1:0]     uart_pins;
  logic [SIG_IDX_WIDTH-1:0] owner_sig [PIN_COUNT];
  logic [SIG_COUNT-1:0]     placed;

  always_comb
  begin
    uart_pins              = '0;
    uart_pins[UART_TX_PIN] = uart_route_en;
    uart_pins[UART_RX_PIN] = uart_route_en;
  end

  // Fully combinational scan; it settles within a cycle for these pin counts.
  // A much larger pin count would need the scan split over several cycles.
  always_comb
  begin
    logic [PIN_COUNT-1:0] taken;
    logic                 found;
    taken  = uart_pins;
    found  = 1'b0;
    placed = '0;
    for (int p = 0; p < PIN_COUNT; p++)
      owner_sig[p] = SIG_NONE;
    for (int s = 0; s < SIG_COUNT; s++)
    begin
      found = 1'b0;
      for (int p = 0; p < PIN_COUNT; p++)
      begin
        if (sig_req[s] && !found && !pin_skip_mask[p] && !taken[p])
        begin
          found        = 1'b1;
          taken[p]     = 1'b1;
          owner_sig[p] = SIG_IDX_WIDTH'(s);
          placed[s]    = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin ownership
  // ---------------------------------------------------------------
  pxb_owner_type        owner      [PIN_COUNT];
  logic [PIN_COUNT-1:0] drive_en;
  logic [PIN_COUNT-1:0] drive_val;
  logic [PIN_COUNT-1:0] force_od;

  always_comb
  begin
    for (int p = 0; p < PIN_COUNT; p++)
    begin
      drive_en[p]  = 1'b0;
      drive_val[p] = 1'b1;
      force_od[p]  = 1'b0;
      // The serial pins are claimed even when skipped, since their place is fixed.
      if (uart_pins[p])
        owner[p] = OWN_UART;
      else if (owner_sig[p] != SIG_NONE)
        owner[p] = OWN_XBAR;
      else
        owner[p] = OWN_GPIO;
      if (matrix_enable)
      begin
        case (owner[p])
          OWN_UART:
          begin
            drive_en[p]  = (p == UART_TX_PIN);
            drive_val[p] = uart_transmit;
          end
          OWN_XBAR:
          begin
            drive_en[p]  = periph_out_en[owner_sig[p]];
            drive_val[p] = periph_out_val[owner_sig[p]];
            force_od[p]  = (owner_sig[p] == SIG_IDX_WIDTH'(SIG_SDA))
                         | (owner_sig[p] == SIG_IDX_WIDTH'(SIG_SCL));
          end
          // An open-drain port pin only pulls low; a high is left to the pullup.
          OWN_GPIO:
          begin
            drive_en[p]  = 1'b1;
            drive_val[p] = gpio_out_val[p];
          end
          default:
          begin
            drive_en[p]  = 1'b0;
            drive_val[p] = 1'b1;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin cells
  // ---------------------------------------------------------------
  // Every cell shares the global pullup disable; the mode bits are per pin.
  logic [PIN_COUNT-1:0] sense;

  for (genvar p = 0; p < PIN_COUNT; p++)
  begin : g_pin
    pxb_pin_cell u_cell
    (
      .clk_sys          (clk_sys),
      .rst_n            (rst_n),
      .digital_mode     (input_mode_select[p]),
      .push_pull        (output_drive_select[p]),
      .force_open_drain (force_od[p]),
      .pullup_disable   (pullup_disable),
      .drive_en         (drive_en[p]),
      .drive_val        (drive_val[p]),
      .pin_in           (pin_in[p]),
      .pin_out          (pin_out[p]),
      .pin_oe_n         (pin_oe_n[p]),
      .pullup_on        (pin_pullup_en[p]),
      .pin_sense        (sense[p])
    );
  end

  assign port_in_val = sense;

  // ---------------------------------------------------------------
  // Inputs returned to peripherals
  // ---------------------------------------------------------------
  // Values lag the pins by four cycles: two for the synchroniser, one in the pin cell, one here.
  // Slots with no pin read 0, and the serial receive line idles high.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      uart_receive  <= 1'b1;
      periph_in_val <= '0;
      sig_placed    <= '0;
    end
    else
    begin
      uart_receive <= (matrix_enable & uart_route_en) ? sense[UART_RX_PIN] : 1'b1;
      for (int s = 0; s < SIG_COUNT; s++)
      begin
        periph_in_val[s] <= 1'b0;
        for (int p = 0; p < PIN_COUNT; p++)
          if (matrix_enable && owner_sig[p] == SIG_IDX_WIDTH'(s))
            periph_in_val[s] <= sense[p];
      end
      sig_placed <= matrix_enable ? placed : '0;
    end
  end

endmodule

// *** verif/pxb_crossbar_props.sv ***
// Checker of the port crossbar pad outputs and signal placement flags.
`timescale 1ns/1ns
module pxb_crossbar_props
  import pxb_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 nrst,
  input wire logic [PIN_COUNT-1:0] pin_skip_mask,
  input wire logic [PIN_COUNT-1:0] input_mode_select,
  input wire logic [PIN_COUNT-1:0] output_drive_select,
  input wire logic                 matrix_enable,
  input wire logic                 pullup_disable,
  input wire logic                 uart_route_en,
  input wire logic                 spi_route_en,
  input wire logic                 spi_four_wire,
  input wire logic                 smbus_route_en,
  input wire logic [1:0]           counter_array_route_field,
  input wire logic                 uart_transmit,
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe_n,
  input wire logic [PIN_COUNT-1:0] pin_pullup_en,
  input wire logic [SIG_COUNT-1:0] sig_placed
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence uart_pp_s;
    matrix_enable && uart_route_en && output_drive_select[UART_TX_PIN] && input_mode_select[UART_TX_PIN];
  endsequence
  sequence spi_free_s;
    matrix_enable && spi_route_en && !uart_route_en && !pin_skip_mask[0];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  off_drive_a: assert property (!$past(matrix_enable) |-> &pin_oe_n) else $error("drive while off");
  off_place_a: assert property (!$past(matrix_enable) |-> sig_placed == '0) else $error("placed while off");
  analog_quiet_a: assert property ((~$past(input_mode_select) & (~pin_oe_n | pin_pullup_en)) == '0)
    else $error("analog pin active");
  low_pull_a: assert property ((~pin_oe_n & ~pin_out & pin_pullup_en) == '0) else $error("pullup on low");
  pud_off_a: assert property ($past(pullup_disable) |-> pin_pullup_en == '0) else $error("pullup disabled");
  pp_pull_a: assert property (!$past(smbus_route_en) |-> (pin_pullup_en & $past(output_drive_select)) == '0)
    else $error("pullup on push-pull");
  od_pull_a: assert property (!$past(pullup_disable)
    |-> (~pin_oe_n | pin_pullup_en | $past(output_drive_select | ~input_mode_select)) == '1) else $error("pullup missing");
  three_wire_a: assert property (!$past(spi_four_wire) |-> !sig_placed[SIG_SS]) else $error("select placed");
  cex_field_a: assert property (sig_placed[SIG_CEX2] |-> $past(counter_array_route_field) == CEX_ALL)
    else $error("channel 2 placed");
  uart_tx_a: assert property (uart_pp_s |=> !pin_oe_n[UART_TX_PIN] && pin_out[UART_TX_PIN] == $past(uart_transmit))
    else $error("transmit pin wrong");
  spi_first_a: assert property (spi_free_s |=> sig_placed[SIG_SCK]) else $error("clock not placed");
endmodule

// *** verif/pxb_pad_model.sv ***
// Pad and board model that resolves each pin's level.
`timescale 1ns/1ns
module pxb_pad_model
  import pxb_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] pin_out,
  input  wire logic [PIN_COUNT-1:0] pin_oe_n,
  input  wire logic [PIN_COUNT-1:0] pin_pullup_en,
  input  wire logic [PIN_COUNT-1:0] ext_level,
  output logic      [PIN_COUNT-1:0] pin_in
);
  always_comb
  begin
    for (int p = 0; p < PIN_COUNT; p++)
      pin_in[p] = !pin_oe_n[p] ? pin_out[p] : (pin_pullup_en[p] ? 1'b1 : ext_level[p]);
  end
endmodule

// *** verif/tb_pxb_crossbar.sv ***
// Self-checking bench of the port crossbar.
`timescale 1ns/1ns
module tb_pxb_crossbar;
  import pxb_pkg::*;
  logic                 clk_sys = 1'b0;
  logic                 nrst = 1'b0;
  logic [PIN_COUNT-1:0] pin_skip_mask = '0;
  logic [PIN_COUNT-1:0] input_mode_select = '1;
  logic [PIN_COUNT-1:0] output_drive_select = '0;
  logic [PIN_COUNT-1:0] gpio_out_val = '0;
  logic [PIN_COUNT-1:0] ext_level = '0;
  logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, port_in_val, e_oe, e_out, e_pu, e_lv;
  logic [SIG_COUNT-1:0] periph_out_val = '0;
  logic [SIG_COUNT-1:0] periph_out_en = '0;
  logic [SIG_COUNT-1:0] periph_in_val, sig_placed, e_pl, e_in;
  logic [1:0]           counter_array_route_field = '0;
  logic                 matrix_enable = 0, pullup_disable = 0, uart_route_en = 0, spi_route_en = 0;
  logic                 spi_four_wire = 0, smbus_route_en = 0, cmp_route_en = 0, cmp_async_route_en = 0;
  logic                 sysclk_route_en = 0, eci_route_en = 0, t0_route_en = 0, t1_route_en = 0;
  logic                 uart_transmit = 0, uart_receive, e_rx;
  logic [31:0]          lfsr = 32'hceedb808, r;
  int                   num_errors = 0, total_checks = 0, cycles = 0;

  pxb_crossbar u_pxb_crossbar (.clk_sys, .nrst, .pin_skip_mask, .input_mode_select, .output_drive_select,
    .matrix_enable, .pullup_disable, .uart_route_en, .spi_route_en, .spi_four_wire, .smbus_route_en,
    .cmp_route_en, .cmp_async_route_en, .sysclk_route_en, .counter_array_route_field, .eci_route_en,
    .t0_route_en, .t1_route_en, .gpio_out_val, .uart_transmit, .periph_out_val, .periph_out_en, .pin_in,
    .pin_out, .pin_oe_n, .pin_pullup_en, .port_in_val, .uart_receive, .periph_in_val, .sig_placed);
  pxb_pad_model u_pxb_pad_model (.pin_out, .pin_oe_n, .pin_pullup_en, .ext_level, .pin_in);

  always #5 clk_sys = ~clk_sys;

  function automatic logic [31:0] next_rand();
    for (int i = 0; i < 32; i++)
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // ----------------------------------------
  // Expected pin assignment
  // ----------------------------------------
  function automatic void expect_pins();
    logic [PIN_COUNT-1:0] taken, asg;
    logic [SIG_COUNT-1:0] want;
    logic                 od;
    int                   p;
    taken = pin_skip_mask;
    asg = '0;
    e_pl = '0;
    e_oe = '1;
    e_out = gpio_out_val;
    e_pu = '0;
    e_in = '0;
    want = {t1_route_en, t0_route_en, eci_route_en, counter_array_route_field == CEX_ALL,
            counter_array_route_field[1], counter_array_route_field != CEX_NONE, sysclk_route_en,
            cmp_async_route_en, cmp_route_en, smbus_route_en, smbus_route_en,
            spi_route_en & spi_four_wire, spi_route_en, spi_route_en, spi_route_en};
    if (uart_route_en)
      taken[UART_RX_PIN:UART_TX_PIN] = 2'h3;
    for (int s = 0; s < SIG_COUNT; s++)
    begin
      p = 0;
      while (want[s] && p < PIN_COUNT && taken[p])
        p++;
      if (want[s] && p < PIN_COUNT)
      begin
        taken[p] = 1'b1;
        asg[p] = 1'b1;
        e_pl[s] = 1'b1;
        od = !output_drive_select[p] || s == SIG_SDA || s == SIG_SCL;
        e_oe[p] = !(periph_out_en[s] && !(od && periph_out_val[s]));
        e_out[p] = periph_out_val[s];
        e_pu[p] = od && !pullup_disable && !(periph_out_en[s] && !periph_out_val[s]);
        e_in[s] = !e_oe[p] ? periph_out_val[s] : (e_pu[p] | ext_level[p]);
      end
    end
    for (int q = 0; q < PIN_COUNT; q++)
      if (!asg[q])
      begin
        e_oe[q] = output_drive_select[q] ? 1'b0 : gpio_out_val[q];
        e_pu[q] = !output_drive_select[q] && !pullup_disable && gpio_out_val[q];
      end
    if (uart_route_en)
    begin
      e_oe[UART_TX_PIN] = output_drive_select[UART_TX_PIN] ? 1'b0 : uart_transmit;
      e_out[UART_TX_PIN] = uart_transmit;
      e_oe[UART_RX_PIN] = 1'b1;
      e_pu[UART_TX_PIN] = !output_drive_select[UART_TX_PIN] && !pullup_disable && uart_transmit;
      e_pu[UART_RX_PIN] = !output_drive_select[UART_RX_PIN] && !pullup_disable;
    end
    e_oe = e_oe | ~input_mode_select;
    e_pu = e_pu & input_mode_select;
    for (int q = 0; q < PIN_COUNT; q++)
      e_lv[q] = input_mode_select[q] & (!e_oe[q] ? e_out[q] : (e_pu[q] | ext_level[q]));
    e_rx = !uart_route_en | e_lv[UART_RX_PIN];
  endfunction

  task automatic cmp_pins(input logic [PIN_COUNT-1:0] got, input logic [PIN_COUNT-1:0] exp,
                          input logic [PIN_COUNT-1:0] msk);
    total_checks++;
    if ((got & msk) !== (exp & msk))
    begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
    end
  endtask

  task automatic cmp_slots(input logic [SIG_COUNT-1:0] got, input logic [SIG_COUNT-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1'b1;
    step(4);
    pullup_disable = 1'b1;
    uart_route_en = 1'b1;
    spi_route_en = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ext_level = 24'(next_rand());
      if (i > 0)
        input_mode_select = 24'(next_rand());
      step(6);
      cmp_pins(port_in_val, input_mode_select & ext_level, '1);
      cmp_slots(periph_in_val, '0);
      cmp_pins(24'(uart_receive), 24'h1, 24'h1);
    end
    input_mode_select = '1;
    pullup_disable = 1'b0;
    uart_route_en = 1'b0;
    spi_route_en = 1'b0;
    gpio_out_val = 24'(next_rand());
    matrix_enable = 1'b1;
    step(6);
    cmp_pins(pin_oe_n, gpio_out_val, '1);
    cmp_pins(pin_pullup_en, gpio_out_val, '1);
    cmp_pins(port_in_val, gpio_out_val, '1);
    for (int i = 0; i < 40; i++)
    begin
      r = (i == 0) ? '1 : next_rand();
      input_mode_select = (i < 3) ? '1 : 24'(next_rand() | next_rand());
      output_drive_select = 24'(next_rand());
      pin_skip_mask = (i == 0) ? '0 : (i == 1) ? '1 : (i == 2) ? 24'hfffff0 : 24'(next_rand() & next_rand());
      pin_skip_mask = pin_skip_mask | ~input_mode_select;
      {uart_route_en, spi_route_en, spi_four_wire, smbus_route_en, cmp_route_en, cmp_async_route_en,
       sysclk_route_en, eci_route_en, t0_route_en, t1_route_en, counter_array_route_field} = r[11:0];
      periph_out_val = 15'(next_rand());
      periph_out_en = 15'(next_rand() | next_rand());
      gpio_out_val = 24'(next_rand());
      uart_transmit = r[12];
      pullup_disable = r[13];
      step(2);
      expect_pins();
      cmp_slots(sig_placed, e_pl);
      cmp_pins(pin_oe_n, e_oe, '1);
      cmp_pins(pin_out, e_out, ~e_oe);
      cmp_pins(pin_pullup_en, e_pu, '1);
      step(4);
      cmp_pins(port_in_val, e_lv, '1);
      cmp_slots(periph_in_val, e_in);
      cmp_pins(24'(uart_receive), 24'(e_rx), 24'h1);
    end
    matrix_enable = 1'b0;
    step(2);
    cmp_slots(sig_placed, '0);
    cmp_pins(pin_oe_n, '1, '1);
    final_report();
  end
endmodule

bind pxb_crossbar pxb_crossbar_props u_pxb_crossbar_props (.clk_sys, .nrst, .pin_skip_mask, .input_mode_select,
  .output_drive_select, .matrix_enable, .pullup_disable, .uart_route_en, .spi_route_en, .spi_four_wire,
  .smbus_route_en, .counter_array_route_field, .uart_transmit, .pin_out, .pin_oe_n, .pin_pullup_en, .sig_placed);
